//--- dlic_ctrl.sv
`timescale 1ns/1ps
`include "dlic_consts.svh"

module dlic_ctrl (
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  wire dlic_pkg::dlic_wb_req_t WB_REQ,
    output logic [31:0]                 WB_DAT_O,
    output logic                        WB_ACK_O,
    output logic                        WB_ERR_O,
    input  wire logic [31:0]            PERIPH_REQ,
    input  wire logic                   PWM_TRIP,
    input  wire logic                   PWM_SYNC,
    input  wire logic [3:0]             EXT_REQUEST_PIN,
    output dlic_pkg::dlic_req_out_t     CORE_REQ
);
    import dlic_pkg::*;

    // =========================================================
    // address decode
    // =========================================================
    typedef enum logic [3:0] {
        DLIC_SEL_NONE, DLIC_SEL_NST, DLIC_SEL_NRAW, DLIC_SEL_NEN, DLIC_SEL_NCLR,
        DLIC_SEL_SWT, DLIC_SEL_FST, DLIC_SEL_FRAW, DLIC_SEL_FEN, DLIC_SEL_FCLR
    } dlic_sel_t;

    function automatic dlic_sel_t decode(input logic [31:0] adr);
        unique case (adr)
            `DLIC_ADDR_NORMAL_STATUS:   decode = DLIC_SEL_NST;
            `DLIC_ADDR_NORMAL_RAW:      decode = DLIC_SEL_NRAW;
            `DLIC_ADDR_NORMAL_ENABLE:   decode = DLIC_SEL_NEN;
            `DLIC_ADDR_NORMAL_EN_CLEAR: decode = DLIC_SEL_NCLR;
            `DLIC_ADDR_SW_TRIGGER:      decode = DLIC_SEL_SWT;
            `DLIC_ADDR_FAST_STATUS:     decode = DLIC_SEL_FST;
            `DLIC_ADDR_FAST_RAW:        decode = DLIC_SEL_FRAW;
            `DLIC_ADDR_FAST_ENABLE:     decode = DLIC_SEL_FEN;
            `DLIC_ADDR_FAST_EN_CLEAR:   decode = DLIC_SEL_FCLR;
            default:                    decode = DLIC_SEL_NONE;
        endcase
    endfunction

    // byte enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            lane_mask[i*8 +: 8] = {8{sel[i]}};
        end
    endfunction

    // =========================================================
    // source synchronisers
    // =========================================================
    // pins and peripheral lines may come from other clocks
    logic [3:0]  ext_meta_ff;
    logic [3:0]  ext_sync_ff;
    logic [31:0] per_meta_ff;
    logic [31:0] per_sync_ff;
    logic [1:0]  pwm_meta_ff;
    logic [1:0]  pwm_sync_ff;
    logic [3:0]  nxt_ext_meta;
    logic [31:0] nxt_per_meta;
    logic [1:0]  nxt_pwm_meta;

    always_comb begin
        nxt_ext_meta = EXT_REQUEST_PIN;
        nxt_per_meta = PERIPH_REQ;
        nxt_pwm_meta = {PWM_SYNC, PWM_TRIP};
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ext_meta_ff <= 4'h0;
            ext_sync_ff <= 4'h0;
            per_meta_ff <= 32'h0;
            per_sync_ff <= 32'h0;
            pwm_meta_ff <= 2'h0;
            pwm_sync_ff <= 2'h0;
        end else begin
            ext_meta_ff <= nxt_ext_meta;
            ext_sync_ff <= ext_meta_ff;
            per_meta_ff <= nxt_per_meta;
            per_sync_ff <= per_meta_ff;
            pwm_meta_ff <= nxt_pwm_meta;
            pwm_sync_ff <= pwm_meta_ff;
        end
    end

    // =========================================================
    // register write decode
    // =========================================================
    logic        wb_hit;
    logic        wr_stb;
    dlic_sel_t   sel_dec;
    logic [31:0] wmask;
    logic [31:0] wbits;

    always_comb begin
        sel_dec = decode(WB_REQ.adr);
        wb_hit  = WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O && !WB_ERR_O;
        wr_stb  = wb_hit && WB_REQ.we;
        wmask   = lane_mask(WB_REQ.sel);
        wbits   = WB_REQ.dat & wmask & `DLIC_IMPL_MASK;
    end

    // =========================================================
    // enable masks and software trigger
    // =========================================================
    logic [31:0] nen_ff;
    logic [31:0] fen_ff;
    logic [1:0]  swt_ff;
    logic [31:0] nxt_nen;
    logic [31:0] nxt_fen;
    logic [1:0]  nxt_swt;

    always_comb begin
        nxt_nen = nen_ff;
        nxt_fen = fen_ff;
        nxt_swt = swt_ff;
        if (wr_stb) begin
            unique case (sel_dec)
                DLIC_SEL_NEN: begin
                    nxt_nen = nen_ff | wbits;
                    nxt_fen = fen_ff & ~wbits;
                end
                DLIC_SEL_FEN: begin
                    nxt_fen = fen_ff | wbits;
                    nxt_nen = nen_ff & ~wbits;
                end
                DLIC_SEL_NCLR: nxt_nen = nen_ff & ~wbits;
                DLIC_SEL_FCLR: nxt_fen = fen_ff & ~wbits;
                DLIC_SEL_SWT: begin
                    // a byte lane left out keeps its trigger bit
                    if (WB_REQ.sel[0]) begin
                        nxt_swt = {WB_REQ.dat[`DLIC_BIT_SWT_FAST],
                                   WB_REQ.dat[`DLIC_BIT_SWT_NORMAL]};
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            nen_ff <= `DLIC_RST_ENABLE;
            fen_ff <= `DLIC_RST_ENABLE;
            swt_ff <= `DLIC_RST_SW_TRIGGER;
        end else begin
            nen_ff <= nxt_nen;
            fen_ff <= nxt_fen;
            swt_ff <= nxt_swt;
        end
    end

    // =========================================================
    // raw signals, status and requests
    // =========================================================
    // raw vectors are combinational from synchronised sources; no vector or
    // priority is formed, software scans the status word
    logic [31:0] src_common;
    logic [31:0] nraw;
    logic [31:0] fraw;
    logic [31:0] nsta;
    logic [31:0] fsta;
    logic        fast_or;

    always_comb begin
        src_common = per_sync_ff & `DLIC_IMPL_MASK;
        src_common[`DLIC_BIT_SW_SOURCE] = 1'b0;
        src_common[`DLIC_BIT_EXT0] = ext_sync_ff[0];
        src_common[`DLIC_BIT_EXT1] = ext_sync_ff[1];
        src_common[`DLIC_BIT_EXT2] = ext_sync_ff[2];
        src_common[`DLIC_BIT_EXT3] = ext_sync_ff[3];
        fraw = src_common;
        fraw[`DLIC_BIT_PWM] = pwm_sync_ff[1];
        fraw[`DLIC_BIT_SW_SOURCE] = swt_ff[1];
        // fast status bits ignore the mask for the software source
        fsta = fraw & (fen_ff | 32'h00000002);
        fsta[`DLIC_BIT_FAST_OR] = 1'b0;
        fast_or = |fsta[31:1];
        fsta[`DLIC_BIT_FAST_OR] = fast_or;
        fraw[`DLIC_BIT_FAST_OR] = fast_or;
        nraw = src_common;
        nraw[`DLIC_BIT_PWM] = pwm_sync_ff[0];
        nraw[`DLIC_BIT_SW_SOURCE] = swt_ff[0];
        nraw[`DLIC_BIT_FAST_OR] = fast_or;
        nsta = nraw & (nen_ff | 32'h00000002);
        nsta[`DLIC_BIT_FAST_OR] = fast_or;
    end

    // registered request levels, one cycle after the status word changes
    dlic_req_out_t req_ff;
    dlic_req_out_t nxt_req;

    always_comb begin
        nxt_req.normal = |nsta;
        nxt_req.fast   = fast_or;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            req_ff <= '0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    assign CORE_REQ = req_ff;

    // =========================================================
    // wishbone answer
    // =========================================================
    // one wait state: ack comes the edge after the request is seen
    logic        ack_ff;
    logic        err_ff;
    logic [31:0] rdat_ff;
    logic        nxt_ack;
    logic        nxt_err;
    logic [31:0] nxt_rdat;

    always_comb begin
        nxt_ack  = 1'b0;
        nxt_err  = 1'b0;
        nxt_rdat = 32'h0;
        if (wb_hit) begin
            if (sel_dec == DLIC_SEL_NONE) begin
                nxt_err = 1'b1;
            end else begin
                nxt_ack = 1'b1;
            end
            if (!WB_REQ.we) begin
                unique case (sel_dec)
                    DLIC_SEL_NST:  nxt_rdat = nsta;
                    DLIC_SEL_NRAW: nxt_rdat = nraw;
                    DLIC_SEL_NEN:  nxt_rdat = nen_ff;
                    DLIC_SEL_FST:  nxt_rdat = fsta;
                    DLIC_SEL_FRAW: nxt_rdat = fraw;
                    DLIC_SEL_FEN:  nxt_rdat = fen_ff;
                    default:       nxt_rdat = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_ff  <= 1'b0;
            err_ff  <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff  <= nxt_ack;
            err_ff  <= nxt_err;
            rdat_ff <= nxt_rdat;
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_ERR_O = err_ff;
    assign WB_DAT_O = rdat_ff;

endmodule

//--- dlic_consts.svh
`ifndef DLIC_CONSTS_SVH
`define DLIC_CONSTS_SVH

// register byte addresses
`define DLIC_ADDR_NORMAL_STATUS    32'hffff0000
`define DLIC_ADDR_NORMAL_RAW       32'hffff0004
`define DLIC_ADDR_NORMAL_ENABLE    32'hffff0008
`define DLIC_ADDR_NORMAL_EN_CLEAR  32'hffff000c
`define DLIC_ADDR_SW_TRIGGER       32'hffff0010
`define DLIC_ADDR_FAST_STATUS      32'hffff0100
`define DLIC_ADDR_FAST_RAW         32'hffff0104
`define DLIC_ADDR_FAST_ENABLE      32'hffff0108
`define DLIC_ADDR_FAST_EN_CLEAR    32'hffff010c

// reset values
`define DLIC_RST_ENABLE            32'h00000000
`define DLIC_RST_SW_TRIGGER        2'h0

// field positions
`define DLIC_BIT_FAST_OR           0
`define DLIC_BIT_SW_SOURCE         1
`define DLIC_BIT_SWT_NORMAL        1
`define DLIC_BIT_SWT_FAST          2
`define DLIC_BIT_EXT0              15
`define DLIC_BIT_EXT1              18
`define DLIC_BIT_EXT2              21
`define DLIC_BIT_EXT3              22
`define DLIC_BIT_PWM               23

// bits 24..31 are reserved: no source, enable bits held at zero
`define DLIC_IMPL_MASK             32'h00fffffe

`endif

//--- dlic_pkg.sv
package dlic_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [31:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } dlic_wb_req_t;

    typedef struct packed {
        logic        normal;
        logic        fast;
    } dlic_req_out_t;

endpackage

//--- dlic_core_model.sv
`timescale 1ns/1ps
module dlic_core_model
    import dlic_pkg::*;
(
    input  wire logic         clk,
    output dlic_wb_req_t      wb_req,
    input  wire logic [31:0]  dat_i,
    input  wire logic         ack_i,
    input  wire logic         err_i
);
    initial wb_req = '0;
    // =========================================
    // classic cycle: hold until ack/err, then one idle cycle
    task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        @(posedge clk);
        while (!(ack_i || err_i)) @(posedge clk);
        rd = dat_i;
        err = err_i;
        wb_req <= '0;
        @(posedge clk);
    endtask
endmodule

//--- dlic_ctrl_props.sv
`timescale 1ns/1ps
`include "dlic_consts.svh"
module dlic_ctrl_props
    import dlic_pkg::*;
(
    input wire logic          CLK,
    input wire logic          RST,
    input wire dlic_wb_req_t  WB_REQ,
    input wire logic [31:0]   WB_DAT_O,
    input wire logic          WB_ACK_O,
    input wire logic          WB_ERR_O,
    input wire logic [31:0]   PERIPH_REQ,
    input wire logic          PWM_TRIP,
    input wire logic          PWM_SYNC,
    input wire logic [3:0]    EXT_REQUEST_PIN,
    input wire dlic_req_out_t CORE_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic        take;
    logic        wo_adr;
    logic        mapped;
    logic [37:0] src_ff;
    logic [2:0]  quiet_ff;
    logic [2:0]  nxt_quiet;
    assign take = WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O && !WB_ERR_O;
    assign wo_adr = WB_REQ.adr inside {`DLIC_ADDR_NORMAL_EN_CLEAR, `DLIC_ADDR_SW_TRIGGER,
                                       `DLIC_ADDR_FAST_EN_CLEAR};
    assign mapped = wo_adr || (WB_REQ.adr inside {`DLIC_ADDR_NORMAL_STATUS,
        `DLIC_ADDR_NORMAL_RAW, `DLIC_ADDR_NORMAL_ENABLE, `DLIC_ADDR_FAST_STATUS,
        `DLIC_ADDR_FAST_RAW, `DLIC_ADDR_FAST_ENABLE});
    // quiet time since any source moved or a write was taken; requests must settle by 5
    always_comb begin
        if ({PERIPH_REQ, PWM_TRIP, PWM_SYNC, EXT_REQUEST_PIN} != src_ff || (take && WB_REQ.we))
            nxt_quiet = 3'h0;
        else
            nxt_quiet = (quiet_ff == 3'h7) ? 3'h7 : quiet_ff + 3'h1;
    end
    always_ff @(posedge CLK) begin
        src_ff <= {PERIPH_REQ, PWM_TRIP, PWM_SYNC, EXT_REQUEST_PIN};
        quiet_ff <= RST ? 3'h0 : nxt_quiet;
    end
    property p_answer; take |=> (WB_ACK_O ^ WB_ERR_O); endproperty
    property p_no_stray; !take |=> !WB_ACK_O && !WB_ERR_O; endproperty
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    property p_err_unmapped; take && !mapped |=> WB_ERR_O; endproperty
    property p_wo_zero; take && !WB_REQ.we && wo_adr |=> WB_DAT_O == 32'h0; endproperty
    property p_fast_in_normal; $rose(CORE_REQ.fast) |-> ##[0:2] CORE_REQ.normal; endproperty
    property p_rst_quiet;
        $fell(RST) |-> !CORE_REQ.normal && !CORE_REQ.fast && !WB_ACK_O;
    endproperty
    property p_req_stable; quiet_ff >= 3'h5 |-> $stable(CORE_REQ); endproperty
    a_answer: assert property (p_answer) else $error("bus request not answered");
    a_no_stray: assert property (p_no_stray) else $error("answer without request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    a_wo_zero: assert property (p_wo_zero) else $error("write-only read not zero");
    a_fast_in_normal: assert property (p_fast_in_normal) else $error("fast not in normal");
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    a_req_stable: assert property (p_req_stable) else $error("request moved on its own");
    c_fast: cover property ($rose(CORE_REQ.fast));
    c_normal: cover property ($rose(CORE_REQ.normal));
    c_err: cover property ($rose(WB_ERR_O));
endmodule
bind dlic_ctrl dlic_ctrl_props u_props (.CLK(CLK), .RST(RST), .WB_REQ(WB_REQ),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .PERIPH_REQ(PERIPH_REQ),
    .PWM_TRIP(PWM_TRIP), .PWM_SYNC(PWM_SYNC), .EXT_REQUEST_PIN(EXT_REQUEST_PIN),
    .CORE_REQ(CORE_REQ));

//--- test_dlic_ctrl.sv
`timescale 1ns/1ps
`include "dlic_consts.svh"
module test_dlic_ctrl;
    import dlic_pkg::*;
    localparam logic [31:0] M = `DLIC_IMPL_MASK;
    logic          CLK = 1'b0;
    logic          RST = 1'b1;
    dlic_wb_req_t  wb_req;
    dlic_req_out_t core_req;
    logic [31:0]   dat_o, rd, w, nen, fen;
    logic [31:0]   periph = '0;
    logic [3:0]    ext = '0;
    logic          trip = 1'b0, sync = 1'b0, ack, err, rerr;
    logic [1:0]    swt;
    integer        err_total = 0, checks_done = 0, seed = 32'h88081fe5, i;
    logic [31:0]   regs [9] = '{`DLIC_ADDR_NORMAL_STATUS, `DLIC_ADDR_NORMAL_RAW,
        `DLIC_ADDR_NORMAL_ENABLE, `DLIC_ADDR_NORMAL_EN_CLEAR, `DLIC_ADDR_SW_TRIGGER,
        `DLIC_ADDR_FAST_STATUS, `DLIC_ADDR_FAST_RAW, `DLIC_ADDR_FAST_ENABLE,
        `DLIC_ADDR_FAST_EN_CLEAR};
    dlic_ctrl dut (.CLK(CLK), .RST(RST), .WB_REQ(wb_req), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .WB_ERR_O(err), .PERIPH_REQ(periph), .PWM_TRIP(trip), .PWM_SYNC(sync),
        .EXT_REQUEST_PIN(ext), .CORE_REQ(core_req));
    dlic_core_model core (.clk(CLK), .wb_req(wb_req), .dat_i(dat_o), .ack_i(ack), .err_i(err));
    always #12.5 CLK = ~CLK;
    // =========================================
    // expectations
    function automatic logic [31:0] raw_of(input logic fast);
        logic [31:0] r;
        r = periph & 32'h001b7ffc;
        r[15] = ext[0];
        r[18] = ext[1];
        r[21] = ext[2];
        r[22] = ext[3];
        r[23] = fast ? sync : trip;
        r[1] = fast ? swt[1] : swt[0];
        return r;
    endfunction
    function automatic logic fast_or();
        logic [31:0] f;
        f = raw_of(1'b1) & (fen | 32'h2);
        return |f[31:1];
    endfunction
    function automatic logic [31:0] stat_of(input logic fast);
        return (raw_of(fast) & ((fast ? fen : nen) | 32'h2)) | {31'h0, fast_or()};
    endfunction
    // =========================================
    // checks and bus access
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        core.xfer(1'b1, a, d, rd, rerr);
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] e);
        core.xfer(1'b0, a, 32'h0, rd, rerr);
        chk(what, e, rd);
    endtask
    task automatic check_all;
        rd_chk("normal raw", `DLIC_ADDR_NORMAL_RAW, raw_of(0) | fast_or());
        rd_chk("fast raw", `DLIC_ADDR_FAST_RAW, raw_of(1) | fast_or());
        rd_chk("normal enable", `DLIC_ADDR_NORMAL_ENABLE, nen);
        rd_chk("fast enable", `DLIC_ADDR_FAST_ENABLE, fen);
        rd_chk("normal status", `DLIC_ADDR_NORMAL_STATUS, stat_of(0));
        rd_chk("fast status", `DLIC_ADDR_FAST_STATUS, stat_of(1));
        rd_chk("trigger read", `DLIC_ADDR_SW_TRIGGER, 32'h0);
        chk("core req", {30'h0, |stat_of(0), fast_or()}, {30'h0, core_req});
    endtask
    task automatic stop_test;
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // =========================================
    // main sequence
    initial begin
        nen = '0;
        fen = '0;
        swt = '0;
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        for (i = 0; i < 9; i++)
            rd_chk("reset value", regs[i], 32'h0);
        core.xfer(1'b0, 32'hffff0014, 32'h0, rd, rerr);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        for (i = 0; i < 48; i++) begin
            w = $random(seed);
            periph <= w;
            w = $random(seed);
            ext <= w[3:0];
            trip <= w[4];
            sync <= w[5];
            w = $random(seed);
            wr(regs[2 + (i % 4) + ((i % 4) / 2) * 3 + ((i % 4) / 2) * 1 - ((i % 4) / 2)], w);
            case (i % 4)
                0: begin nen = nen | (w & M); fen = fen & ~(w & M); end
                1: nen = nen & ~(w & M);
                2: begin fen = fen | (w & M); nen = nen & ~(w & M); end
                default: fen = fen & ~w;
            endcase
            w = $random(seed);
            wr(`DLIC_ADDR_SW_TRIGGER, w);
            swt = w[2:1];
            repeat (4) @(posedge CLK);
            check_all();
        end
        periph <= '0;
        ext <= '0;
        trip <= 1'b0;
        sync <= 1'b0;
        wr(`DLIC_ADDR_NORMAL_EN_CLEAR, 32'hffffffff);
        wr(`DLIC_ADDR_FAST_EN_CLEAR, 32'hffffffff);
        wr(`DLIC_ADDR_SW_TRIGGER, 32'h0);
        nen = '0;
        fen = '0;
        swt = '0;
        repeat (4) @(posedge CLK);
        check_all();
        stop_test();
    end
    initial begin
        #(25 * 40000);
        err_total++;
        stop_test();
    end
endmodule
